// File: dv/fsc_link_model.sv
// fsc_link_model: behavioural fieldbus master driving the block's link side
// assumes it shares hclk with the block; the bench calls its tasks
`timescale 1ns/100ps
module fsc_link_model (
  input  wire logic       hclk,
  output logic            comm_ok,
  output logic            tx,
  output logic            rx,
  output logic            crc,
  output logic            trouble,
  output logic [6:0]      addr
);
  // ==========================================================
  // link stimulus
  initial
  begin
    {comm_ok, tx, rx, crc, trouble} = '0;
    addr = 7'h7f;
  end
  // one poll: station a receives, then answers; address inverted once released
  task automatic frame(input logic [6:0] a, input int gap);
    @(posedge hclk);
    addr <= a;
    rx   <= 1'b1;
    repeat (gap) @(posedge hclk);
    rx <= 1'b0;
    tx <= 1'b1;
    repeat (gap) @(posedge hclk);
    tx   <= 1'b0;
    addr <= ~a;
  endtask
  task automatic level(input logic ok, input logic tr);
    @(posedge hclk);
    comm_ok <= ok;
    trouble <= tr;
  endtask
  task automatic crc_hit();
    @(posedge hclk);
    crc <= 1'b1;
    @(posedge hclk);
    crc <= 1'b0;
  endtask
endmodule

// File: dv/fsc_station_cfg_assertions.sv
// fsc_station_cfg_assertions: port-level checks on fsc_station_cfg
// assumes one hclk domain and asynchronous active-low reset
`timescale 1ns/100ps
module fsc_station_cfg_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       link_comm_ok,
  input wire logic       link_tx_active,
  input wire logic       link_rx_active,
  input wire logic [6:0] link_station_addr,
  input wire logic       station_hit,
  input wire logic [6:0] station_first,
  input wire logic [6:0] station_last,
  input wire logic [2:0] link_rate_setting,
  input wire logic [2:0] occupied_stations,
  input wire logic [7:0] remote_io_points,
  input wire logic [4:0] remote_reg_words,
  input wire logic       run_indicator,
  input wire logic       transmit_indicator,
  input wire logic       receive_indicator,
  input wire logic       error_indicator,
  input wire logic       irq
);
  // ==========================================================
  // properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  count_code_a: assert property (occupied_stations inside {3'h1, 3'h2, 3'h4})
    else $error("occupied count not 1, 2 or 4");
  start_range_a: assert property (station_first >= 7'h01 && station_last <= 7'h40)
    else $error("occupied range outside 1 to 64");
  run_length_a: assert property (station_last == station_first + 7'(occupied_stations) - 7'h01)
    else $error("range length differs from count");
  hit_window_a: assert property (station_hit == (link_station_addr >= station_first
    && link_station_addr <= station_last)) else $error("station hit wrong");
  rate_code_a: assert property (link_rate_setting <= 3'h4)
    else $error("rate code above 4");
  lamp_follow_a: assert property ({run_indicator, transmit_indicator, receive_indicator}
    == $past({link_comm_ok, link_tx_active, link_rx_active})) else $error("lamps lag");
  io_area_a: assert property (remote_io_points == {occupied_stations, 5'h00}
    && remote_reg_words == {occupied_stations, 2'h0}) else $error("io area size wrong");
  cover property (station_hit && receive_indicator);
  cover property ($rose(irq));
  cover property ($fell(error_indicator));
endmodule

bind fsc_station_cfg fsc_station_cfg_chk i_chk (
  .hclk               (hclk),
  .hresetn            (hresetn),
  .hreadyout          (hreadyout),
  .hresp              (hresp),
  .link_comm_ok       (link_comm_ok),
  .link_tx_active     (link_tx_active),
  .link_rx_active     (link_rx_active),
  .link_station_addr  (link_station_addr),
  .station_hit        (station_hit),
  .station_first      (station_first),
  .station_last       (station_last),
  .link_rate_setting  (link_rate_setting),
  .occupied_stations  (occupied_stations),
  .remote_io_points   (remote_io_points),
  .remote_reg_words   (remote_reg_words),
  .run_indicator      (run_indicator),
  .transmit_indicator (transmit_indicator),
  .receive_indicator  (receive_indicator),
  .error_indicator    (error_indicator),
  .irq                (irq)
);

// File: dv/fsc_station_cfg_bench.sv
// fsc_station_cfg_bench: register and lamp tests through an AHB-Lite master
// assumes the link model drives the link inputs; blink shortened to 8 cycles
`timescale 1ns/100ps
module fsc_station_cfg_bench;
  import fsc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, station_hit;
  logic        link_comm_ok, link_tx_active, link_rx_active, link_crc_error, link_trouble;
  logic        run_indicator, transmit_indicator, receive_indicator, error_indicator, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize, link_rate_setting, occupied_stations, n;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [6:0]  station_first, station_last, link_station_addr, mx;
  logic [7:0]  remote_io_points;
  logic [4:0]  remote_reg_words;
  int          miscompares, comparisons, tg;
  logic        prev_err;
  always #5 hclk = ~hclk;
  assign hready = hreadyout;
  fsc_station_cfg #(
    .BLINK_CYC          (8)
  ) i_dut (
    .hclk               (hclk),
    .hresetn            (hresetn),
    .hsel               (hsel),
    .haddr              (haddr),
    .htrans             (htrans),
    .hwrite             (hwrite),
    .hsize              (hsize),
    .hready             (hready),
    .hwdata             (hwdata),
    .hrdata             (hrdata),
    .hreadyout          (hreadyout),
    .hresp              (hresp),
    .link_comm_ok       (link_comm_ok),
    .link_tx_active     (link_tx_active),
    .link_rx_active     (link_rx_active),
    .link_crc_error     (link_crc_error),
    .link_trouble       (link_trouble),
    .link_station_addr  (link_station_addr),
    .station_hit        (station_hit),
    .station_first      (station_first),
    .station_last       (station_last),
    .link_rate_setting  (link_rate_setting),
    .occupied_stations  (occupied_stations),
    .remote_io_points   (remote_io_points),
    .remote_reg_words   (remote_reg_words),
    .run_indicator      (run_indicator),
    .transmit_indicator (transmit_indicator),
    .receive_indicator  (receive_indicator),
    .error_indicator    (error_indicator),
    .irq                (irq)
  );
  fsc_link_model i_link (.hclk(hclk), .comm_ok(link_comm_ok), .tx(link_tx_active),
    .rx(link_rx_active), .crc(link_crc_error), .trouble(link_trouble),
    .addr(link_station_addr));
  // ==========================================================
  // tasks
  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 100);
    if (hreadyout !== 1'b1)
    begin
      miscompares++;
      print_verdict();
    end
  endtask
  // a single word transfer; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= FSC_HTRANS_NONSEQ;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    miscompares = 0;
    comparisons = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, FSC_CTRL_OFF, 32'h0);
    chk("ctrl", q, 32'h0000_0102);
    bus(1'b0, FSC_VER_OFF, 32'h0);
    chk("version", q, FSC_VERSION);
    bus(1'b0, FSC_GEOM_OFF, 32'h0);
    chk("geom", q, {8'h0, FSC_SYS_PTS, 3'h0, 5'h10, 8'h80});
    chk("span", {station_first, station_last, remote_io_points}, {7'h01, 7'h04, 8'h80});
    for (int c = 0; c < 3; c++)
    begin
      mx = (c == 0) ? FSC_MAX_ONE : (c == 1) ? FSC_MAX_TWO : FSC_MAX_FOUR;
      n  = 3'h1 << c;
      bus(1'b1, FSC_CTRL_OFF, {17'h0, mx, 6'h0, 2'(c)});
      @(posedge hclk);
      chk("span", {station_first, station_last, remote_reg_words}, {mx, mx + 7'(n) - 7'h01, {n, 2'h0}});
      chk("count", occupied_stations, n);
      bus(1'b1, FSC_CTRL_OFF, {17'h0, mx + 7'h01, 6'h0, 2'(c)});
      bus(1'b0, FSC_STATUS_OFF, 32'h0);
      chk("reject", {q[15:8], q[0]}, {1'b0, mx, 1'b1});
    end
    chk("irq masked", irq, 1'b0);
    bus(1'b1, FSC_IRQ_EN_OFF, 32'h0000_000f);
    @(posedge hclk);
    chk("irq", irq, 1'b1);
    bus(1'b1, FSC_IRQ_CLR_OFF, 32'h0000_000f);
    @(posedge hclk);
    chk("irq clear", irq, 1'b0);
    for (int r = 0; r < 6; r++)
    begin
      bus(1'b1, FSC_CTRL_OFF, {13'h0, 3'(r), 16'h0102});
      @(posedge hclk);
      chk("rate", link_rate_setting, (r < 5) ? 3'(r) : FSC_RATE_10M);
    end
    for (int f = 0; f < 4; f++)
    begin
      bus(1'b1, FSC_VAL_IN_OFF, f[1] ? 32'hfffe_7961 : 32'hffff_ffff);
      bus(1'b1, FSC_CTRL_OFF, {11'h0, f[0], 4'h0, 16'h0102});
      bus(1'b0, FSC_VAL_OUT_OFF, 32'h0);
      chk("value", q, {f[1], f[0]} == 2'h3 ? 32'h8001_869f : f[0] ? 32'h8000_0001 : f[1] ? 32'hfffe_7961 : 32'hffff_ffff);
      bus(1'b1, FSC_ACC_HI_OFF, 32'hffff_fff6);
      bus(1'b0, FSC_ACC_HI_OFF, 32'h0);
      chk("accum", q, 32'hffff_fff6);
    end
    i_link.level(1'b1, 1'b0);
    // lamps lag the link by one cycle; look a little after the edge
    fork
      i_link.frame(7'h02, 3);
      begin
        repeat (3) @(posedge hclk);
        #1;
        chk("rx lamp", {receive_indicator, transmit_indicator, station_hit}, 3'b101);
        repeat (3) @(posedge hclk);
        #1;
        chk("tx lamp", {receive_indicator, transmit_indicator, station_hit}, 3'b011);
      end
    join
    i_link.frame(7'h05, 2);
    chk("miss", station_hit, 1'b0);
    chk("run", run_indicator, 1'b1);
    i_link.crc_hit();
    repeat (2) @(posedge hclk);
    chk("crc lamp", error_indicator, 1'b1);
    bus(1'b0, FSC_IRQ_ST_OFF, 32'h0);
    chk("crc status", q[1], 1'b1);
    bus(1'b1, FSC_IRQ_CLR_OFF, 32'h0000_0002);
    repeat (2) @(posedge hclk);
    chk("lamp dark", error_indicator, 1'b0);
    i_link.level(1'b1, 1'b1);
    repeat (2) @(posedge hclk);
    chk("trouble lamp", error_indicator, 1'b1);
    i_link.level(1'b0, 1'b0);
    repeat (2) @(posedge hclk);
    chk("run lost", run_indicator, 1'b0);
    bus(1'b1, FSC_CTRL_OFF, 32'h0100_0102);
    tg = 0;
    prev_err = error_indicator;
    repeat (40)
    begin
      @(posedge hclk);
      tg += (error_indicator !== prev_err) ? 1 : 0;
      prev_err = error_indicator;
    end
    // the 8-cycle divider ticks exactly five times in any 40 edges
    chk("blink", tg, 32'd5);
    bus(1'b1, FSC_CTRL_OFF, 32'h0000_0102);
    repeat (2) @(posedge hclk);
    chk("blink off", error_indicator, 1'b0);
    print_verdict();
  end
endmodule

// File: src/fsc_pkg.sv
// fsc_pkg: constants and types for the fieldbus station configuration block
// assumes a single 100 MHz clock and an AHB-Lite register bus
// ==========================================================================
// Summary of operation
// - acts as remote device station, version 1.10
// - station count codes 0,1,2 mean 1,2,4
// - start station limited to 64/63/61, else rejected
// - occupies consecutive stations from start number
// - start station defaults to 01
// - rate codes 0..4 are 156k,625k,2.5M,5M,10M
// - rate defaults to 156 kbps
// - format 0 two's complement default, 1 sign-magnitude
// - sign-magnitude sets bit 31, magnitude below
// - accumulated value always two's complement
// - run, transmit, receive indicators follow link state
// - error lights on faults, blinks while editing
// - per station 32 points, 4 words each way
package fsc_pkg;
  // ========================================================================
  // register byte offsets
  localparam logic [7:0] FSC_CTRL_OFF    = 8'h00;
  localparam logic [7:0] FSC_STATUS_OFF  = 8'h04;
  localparam logic [7:0] FSC_IRQ_ST_OFF  = 8'h08;
  localparam logic [7:0] FSC_IRQ_CLR_OFF = 8'h0c;
  localparam logic [7:0] FSC_IRQ_EN_OFF  = 8'h10;
  localparam logic [7:0] FSC_VAL_IN_OFF  = 8'h14;
  localparam logic [7:0] FSC_VAL_OUT_OFF = 8'h18;
  localparam logic [7:0] FSC_ACC_LO_OFF  = 8'h1c;
  localparam logic [7:0] FSC_ACC_HI_OFF  = 8'h20;
  localparam logic [7:0] FSC_VER_OFF     = 8'h24;
  localparam logic [7:0] FSC_GEOM_OFF    = 8'h28;
  // ========================================================================
  // control field positions
  localparam int FSC_CNT_LSB  = 0;
  localparam int FSC_STN_LSB  = 8;
  localparam int FSC_RATE_LSB = 16;
  localparam int FSC_FMT_BIT  = 20;
  localparam int FSC_EDIT_BIT = 24;
  // ========================================================================
  // encodings and reset values
  localparam logic [1:0] FSC_CNT_ONE   = 2'h0;
  localparam logic [1:0] FSC_CNT_TWO   = 2'h1;
  localparam logic [1:0] FSC_CNT_FOUR  = 2'h2;
  localparam logic [6:0] FSC_MAX_ONE   = 7'd64;
  localparam logic [6:0] FSC_MAX_TWO   = 7'd63;
  localparam logic [6:0] FSC_MAX_FOUR  = 7'd61;
  localparam logic [6:0] FSC_STN_MIN   = 7'd1;
  localparam logic [2:0] FSC_RATE_156K = 3'h0;
  localparam logic [2:0] FSC_RATE_10M  = 3'h4;
  localparam logic       FSC_FMT_TWOS  = 1'b0;
  localparam logic       FSC_FMT_SMAG  = 1'b1;
  localparam logic [1:0] FSC_CNT_RST   = FSC_CNT_FOUR;
  localparam logic [6:0] FSC_STN_RST   = 7'd1;
  localparam logic [2:0] FSC_RATE_RST  = FSC_RATE_156K;
  localparam logic       FSC_FMT_RST   = FSC_FMT_TWOS;
  localparam logic [31:0] FSC_VERSION  = 32'h0000_0110;
  localparam logic [7:0] FSC_PTS_PER_STN  = 8'd32;
  localparam logic [4:0] FSC_WORDS_PER_STN = 5'd4;
  localparam logic [7:0] FSC_SYS_PTS     = 8'd16;
  // ========================================================================
  // interrupt bits
  localparam int FSC_EV_SET  = 0;
  localparam int FSC_EV_CRC  = 1;
  localparam int FSC_EV_TRBL = 2;
  localparam int FSC_EV_LOST = 3;
  localparam int FSC_NEV     = 4;
  // ========================================================================
  // timing
  localparam int FSC_CLK_HZ       = 100_000_000;
  localparam int FSC_BLINK_HALF_MS = 250;
  localparam int FSC_BLINK_CYC    = FSC_CLK_HZ / 1000 * FSC_BLINK_HALF_MS;
  localparam logic [1:0] FSC_HTRANS_NONSEQ = 2'h2;
endpackage

// File: src/fsc_station_cfg.sv
// fsc_station_cfg: station settings, number format, indicators, AHB-Lite regs
// assumes link-side inputs are synchronous to hclk; single bus master
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module fsc_station_cfg
  import fsc_pkg::*;
#(
  parameter int BLINK_CYC = FSC_BLINK_CYC
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        link_comm_ok,
  input  wire logic        link_tx_active,
  input  wire logic        link_rx_active,
  input  wire logic        link_crc_error,
  input  wire logic        link_trouble,
  input  wire logic [6:0]  link_station_addr,
  output logic             station_hit,
  output logic [6:0]       station_first,
  output logic [6:0]       station_last,
  output logic [2:0]       link_rate_setting,
  output logic [2:0]       occupied_stations,
  output logic [7:0]       remote_io_points,
  output logic [4:0]       remote_reg_words,
  output logic             run_indicator,
  output logic             transmit_indicator,
  output logic             receive_indicator,
  output logic             error_indicator,
  output logic             irq
);
  // ========================================================================
  // state
  typedef struct packed {
    logic [1:0]          cnt;
    logic [6:0]          stn;
    logic [2:0]          rate;
    logic                fmt;
    logic                edit;
    logic                set_err;
    logic [FSC_NEV-1:0]  irq_st;
    logic [FSC_NEV-1:0]  irq_en;
    logic [31:0]         val;
    logic [31:0]         acc_lo;
    logic [31:0]         acc_hi;
    logic [31:0]         rdata;
    logic [7:0]          waddr;
    logic                wpend;
    logic                run;
    logic                tx;
    logic                rx;
    logic                err;
    logic                blink;
  } fsc_state_t;

  fsc_state_t s_q;
  fsc_state_t s_d;
  fsc_tick_if tk ();

  fsc_ticker #(
    .PERIOD  (BLINK_CYC)
  ) u_ticker (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tk      (tk)
  );

  // ========================================================================
  // helpers
  function automatic logic [2:0] stations_of(input logic [1:0] c);
    case (c)
      FSC_CNT_ONE: stations_of = 3'd1;
      FSC_CNT_TWO: stations_of = 3'd2;
      default:     stations_of = 3'd4;
    endcase
  endfunction

  function automatic logic [6:0] max_start(input logic [1:0] c);
    case (c)
      FSC_CNT_ONE: max_start = FSC_MAX_ONE;
      FSC_CNT_TWO: max_start = FSC_MAX_TWO;
      default:     max_start = FSC_MAX_FOUR;
    endcase
  endfunction

  // most negative value has no magnitude in 31 bits; it saturates
  function automatic logic [31:0] to_smag(input logic [31:0] v);
    logic [31:0] mag;
    mag = 32'h0 - v;
    if (!v[31])
      to_smag = v;
    else if (mag[31])
      to_smag = 32'hffff_ffff;
    else
      to_smag = {1'b1, mag[30:0]};
  endfunction

  logic [2:0]  nstn;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;
  logic [31:0] geom_rd;
  logic        addr_ok;
  logic [1:0]  w_cnt;
  logic [6:0]  w_stn;
  logic [2:0]  w_rate;
  logic        w_valid;
  logic [FSC_NEV-1:0] ev;

  assign nstn    = stations_of(s_q.cnt);
  assign addr_ok = hsel && hready && (htrans == FSC_HTRANS_NONSEQ);
  assign w_cnt   = hwdata[FSC_CNT_LSB +: 2];
  assign w_stn   = hwdata[FSC_STN_LSB +: 7];
  assign w_rate  = hwdata[FSC_RATE_LSB +: 3];
  assign w_valid = (w_cnt <= FSC_CNT_FOUR)
                && (w_stn >= FSC_STN_MIN) && (w_stn <= max_start(w_cnt))
                && (w_rate <= FSC_RATE_10M);

  // ========================================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    ev  = '0;
    ctrl_rd = '0;
    stat_rd = '0;
    geom_rd = '0;
    // data phase of a write
    if (s_q.wpend)
    begin
      case (s_q.waddr)
        FSC_CTRL_OFF:
        begin
          s_d.edit = hwdata[FSC_EDIT_BIT];
          if (w_valid)
          begin
            s_d.cnt  = w_cnt;
            s_d.stn  = w_stn;
            s_d.rate = w_rate;
            s_d.fmt  = hwdata[FSC_FMT_BIT];
            s_d.set_err = 1'b0;
          end
          else
          begin
            s_d.set_err = 1'b1;
            ev[FSC_EV_SET] = 1'b1;
          end
        end
        FSC_IRQ_CLR_OFF: s_d.irq_st = s_q.irq_st & ~hwdata[FSC_NEV-1:0];
        FSC_IRQ_EN_OFF:  s_d.irq_en = hwdata[FSC_NEV-1:0];
        FSC_VAL_IN_OFF:  s_d.val    = hwdata;
        FSC_ACC_LO_OFF:  s_d.acc_lo = hwdata;
        FSC_ACC_HI_OFF:  s_d.acc_hi = hwdata;
        default: ;
      endcase
    end
    // link events; set wins over the clear above
    ev[FSC_EV_CRC]  = link_crc_error;
    ev[FSC_EV_TRBL] = link_trouble && !s_q.err;
    ev[FSC_EV_LOST] = s_q.run && !link_comm_ok;
    s_d.irq_st = s_d.irq_st | ev;
    // indicators
    s_d.run = link_comm_ok;
    s_d.tx  = link_tx_active;
    s_d.rx  = link_rx_active;
    if (tk.tick)
      s_d.blink = !s_q.blink;
    if (!s_d.edit)
      s_d.blink = 1'b0;
    s_d.err = s_d.edit ? s_d.blink
            : (s_d.set_err || s_d.irq_st[FSC_EV_CRC] || link_trouble);
    // address phase: capture, read data built from post-write state except the status run/tx/rx bits, station range and geom sizes
    s_d.wpend = addr_ok && hwrite;
    if (addr_ok)
      s_d.waddr = haddr[7:0];
    ctrl_rd[FSC_CNT_LSB +: 2]  = s_d.cnt;
    ctrl_rd[FSC_STN_LSB +: 7]  = s_d.stn;
    ctrl_rd[FSC_RATE_LSB +: 3] = s_d.rate;
    ctrl_rd[FSC_FMT_BIT]       = s_d.fmt;
    ctrl_rd[FSC_EDIT_BIT]      = s_d.edit;
    stat_rd[0] = s_d.set_err;
    stat_rd[1] = s_q.run;
    stat_rd[2] = s_q.tx;
    stat_rd[3] = s_q.rx;
    stat_rd[15:8]  = {1'b0, station_first};
    stat_rd[23:16] = {1'b0, station_last};
    geom_rd[7:0]   = remote_io_points;
    geom_rd[12:8]  = remote_reg_words;
    geom_rd[23:16] = FSC_SYS_PTS;
    if (addr_ok && !hwrite)
    begin
      case (haddr[7:0])
        FSC_CTRL_OFF:    s_d.rdata = ctrl_rd;
        FSC_STATUS_OFF:  s_d.rdata = stat_rd;
        FSC_IRQ_ST_OFF:  s_d.rdata = {28'h0, s_d.irq_st};
        FSC_IRQ_EN_OFF:  s_d.rdata = {28'h0, s_d.irq_en};
        FSC_VAL_IN_OFF:  s_d.rdata = s_d.val;
        FSC_VAL_OUT_OFF: s_d.rdata = s_d.fmt ? to_smag(s_d.val) : s_d.val;
        FSC_ACC_LO_OFF:  s_d.rdata = s_d.acc_lo;
        FSC_ACC_HI_OFF:  s_d.rdata = s_d.acc_hi;
        FSC_VER_OFF:     s_d.rdata = FSC_VERSION;
        FSC_GEOM_OFF:    s_d.rdata = geom_rd;
        default:         s_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q      <= '0;
      s_q.cnt  <= FSC_CNT_RST;
      s_q.stn  <= FSC_STN_RST;
      s_q.rate <= FSC_RATE_RST;
      s_q.fmt  <= FSC_FMT_RST;
    end
    else
      s_q <= s_d;
  end

  // ========================================================================
  // outputs
  assign hrdata    = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // start plus count minus one never passes 64 once the start is checked
  assign station_first = s_q.stn;
  assign station_last  = 7'(s_q.stn + {4'h0, nstn} - 7'd1);
  // is kept by the master's configuration; no overlap check is made here
  assign station_hit = (link_station_addr >= station_first)
                    && (link_station_addr <= station_last);
  assign link_rate_setting = s_q.rate;
  assign occupied_stations = nstn;
  assign remote_io_points  = 8'(FSC_PTS_PER_STN * nstn);
  assign remote_reg_words  = 5'(FSC_WORDS_PER_STN * nstn);

  assign run_indicator      = s_q.run;
  assign transmit_indicator = s_q.tx;
  assign receive_indicator  = s_q.rx;
  assign error_indicator    = s_q.err;
  assign irq                = |(s_q.irq_st & s_q.irq_en);
endmodule

// File: src/fsc_tick_if.sv
// fsc_tick_if: carries the blink enable pulse from the divider to the block
// assumes both ends sit on hclk
`timescale 1ns/100ps
interface fsc_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input  tick);
endinterface

// File: src/fsc_ticker.sv
// fsc_ticker: free-running divider giving a one-cycle enable every PERIOD cycles
// assumes hclk and asynchronous active-low reset
`timescale 1ns/100ps
module fsc_ticker
  import fsc_pkg::*;
#(
  parameter int PERIOD = FSC_BLINK_CYC
)(
  input  wire logic hclk,
  input  wire logic hresetn,
  fsc_tick_if.src   tk
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } fsc_tick_st_t;

  fsc_tick_st_t s_q;
  fsc_tick_st_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= 32'(PERIOD - 1))
    begin
      s_d.cnt  = 32'h0;
      s_d.tick = 1'b1;
    end
    else
      s_d.cnt = s_q.cnt + 32'h1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tk.tick = s_q.tick;
endmodule
